/* File: logic/mxs_pkg.sv */
// Constants for the two-wire controlled five-way 2:1 switch array.
// Assumes the bus master keeps to standard two-wire framing.
// What this block does
// - Load strobe high applies command at once
// - Load strobe applies all staged commands together
// - Soft reset bit honoured on every write
// - Reset opens all switches, output low
// - Read address acknowledged before data goes out
// - Two status bytes, master acknowledges the first
// - Status bit high means switch closed
// - Read bit shows general output level
// - Bits fifteen to six carry switch states
// - Bit three is output level, rest unassigned
// - Address is 1010 plus three select pins
// - Write word: command byte then control byte
// - Command byte: on/off bit plus target code
// - Latest staged command per element wins
package mxs_pkg;
	localparam int       NUM_MUX       = 5;
	localparam int       NUM_SW        = 2 * NUM_MUX;
	localparam logic [3:0] ADDR_FIXED  = 4'ha;   // Upper address nibble
	localparam logic [6:0] CMD_ALL_A   = 7'h00;
	localparam logic [6:0] CMD_ALL_B   = 7'h01;
	localparam logic [6:0] CMD_SW_FIRST = 7'h02;  // Mux1 A, then B, ...
	localparam logic [6:0] CMD_SW_LAST = 7'h0b;
	localparam logic [6:0] CMD_DIS_FIRST = 7'h0e; // Mux1 disabled
	localparam logic [6:0] CMD_DIS_LAST = 7'h12;
	localparam logic [6:0] CMD_GEN_OUT = 7'h14;
	localparam logic [6:0] CMD_ALL_DIS = 7'h1f;
	localparam int       CMD_ON_BIT    = 7;
	localparam int       CTL_LOAD_BIT  = 1;
	localparam int       CTL_RST_N_BIT = 0;
	localparam int       RB_GEN_OUT_BIT = 3;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [10:0] STATE_RESET = 11'h000; // All open, output low
	typedef enum logic [2:0] {
		MXS_IDLE     = 3'b000,
		MXS_ADDR     = 3'b001,
		MXS_ADDR_ACK = 3'b010,
		MXS_WR_BYTE  = 3'b011,
		MXS_WR_ACK   = 3'b100,
		MXS_RD_BYTE  = 3'b101,
		MXS_RD_ACK   = 3'b110
	} mxs_state_t;
endpackage : mxs_pkg

/* File: logic/mxs_sync.sv */
// Two-flop synchroniser for pins that arrive from outside the clock.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/10ps
module mxs_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	// Reset to the idle-high bus level so no false edge follows reset
	always_ff @(posedge clock) begin
		if (!nrst) begin
			meta <= '1;
			q    <= '1;
		end else if (clk_en) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : mxs_sync

/* File: logic/mxs_switch_ctrl.sv */
// Two-wire slave that stages, applies and reads back switch commands.
// Assumes scl and sda are slow against clock (bench scl period 320 ns).
`timescale 1ns/10ps
module mxs_switch_ctrl #(
	parameter bit HAS_GEN_OUT = 1'b1
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic       addr_select_2,
	input  wire logic       addr_select_1,
	input  wire logic       addr_select_0,
	output logic [9:0]      switch_closed,
	output logic            general_output_pin
);
	logic [4:0]          pins_q;
	logic                scl_s;
	logic                sda_s;
	logic [2:0]          addr_q;
	logic                scl_d;
	logic                sda_d;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_seen;
	logic                stop_seen;
	mxs_pkg::mxs_state_t state;
	logic [2:0]          bit_cnt;
	logic                byte_full;
	logic [7:0]          rx_shift;
	logic [7:0]          rx_next;
	logic [7:0]          tx_shift;
	logic [7:0]          cmd_byte;
	logic                second_byte;
	logic                is_read;
	logic                rd_low;
	logic                rd_more;
	logic                ctl_taken;
	logic [10:0]         applied;
	logic [10:0]         staged;
	logic [10:0]         mask;
	logic                cmd_off;
	logic [10:0]         next_staged;
	logic [15:0]         status_word;

	mxs_sync #(
		.W (5)
	) u_sync (
		.clock  (clock),
		.nrst   (nrst),
		.clk_en (clk_en),
		.d      ({scl_in, sda_in, addr_select_2, addr_select_1,
		          addr_select_0}),
		.q      (pins_q)
	);
	assign {scl_s, sda_s, addr_q} = pins_q; // Bus lines, then straps

	// Edge and framing detection on synchronised lines
	always_ff @(posedge clock) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else if (clk_en) begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end
	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
	assign rx_next    = {rx_shift[6:0], sda_s};

	// Element mask touched by a command byte, bit 10 being the output
	function automatic logic [10:0] cmd_mask(input logic [7:0] c);
		logic [6:0]  t;
		logic [10:0] m;
		logic        dis_all;
		t       = c[6:0];
		m       = '0;
		dis_all = (t == mxs_pkg::CMD_ALL_DIS) && !c[mxs_pkg::CMD_ON_BIT];
		for (int i = 0; i < mxs_pkg::NUM_MUX; i++) begin
			if (t == mxs_pkg::CMD_ALL_A || dis_all ||
			    t == mxs_pkg::CMD_SW_FIRST + 7'(2 * i) ||
			    t == mxs_pkg::CMD_DIS_FIRST + 7'(i)) begin
				m[9 - 2 * i] = 1'b1;
			end
			if (t == mxs_pkg::CMD_ALL_B || dis_all ||
			    t == mxs_pkg::CMD_SW_FIRST + 7'(2 * i + 1) ||
			    t == mxs_pkg::CMD_DIS_FIRST + 7'(i)) begin
				m[8 - 2 * i] = 1'b1;
			end
		end
		m[10] = HAS_GEN_OUT && (t == mxs_pkg::CMD_GEN_OUT);
		return m;
	endfunction : cmd_mask

	// Staging: the newest command overwrites what it touches
	assign mask    = cmd_mask(cmd_byte);
	assign cmd_off = (cmd_byte[6:0] >= mxs_pkg::CMD_DIS_FIRST &&
	                  cmd_byte[6:0] <= mxs_pkg::CMD_DIS_LAST) ||
	                 cmd_byte[6:0] == mxs_pkg::CMD_ALL_DIS;
	assign next_staged = (staged & ~mask) |
	                     (mask & {11{cmd_byte[mxs_pkg::CMD_ON_BIT] &
	                                 ~cmd_off}});
	assign ctl_taken = clk_en && scl_rise && state == mxs_pkg::MXS_WR_BYTE &&
	                   second_byte && bit_cnt == mxs_pkg::BIT_LAST;

	// Readback from applied state only; spare bits read zero
	assign status_word = {applied[9:0], 2'b00,
	                      applied[10] & HAS_GEN_OUT, 3'b000};

	// Protocol engine: address, write bytes, read bytes, acknowledges
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state       <= mxs_pkg::MXS_IDLE;
			bit_cnt     <= 3'h0;
			byte_full   <= 1'b0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			cmd_byte    <= 8'h00;
			second_byte <= 1'b0;
			is_read     <= 1'b0;
			rd_low      <= 1'b0;
			rd_more     <= 1'b0;
			sda_oe_n    <= 1'b1;
			sda_out     <= 1'b0;
		end else if (clk_en) begin
			sda_out <= 1'b0; // Open drain: only ever pulls low
			if (start_seen) begin
				// Repeated start is legal anywhere
				state       <= mxs_pkg::MXS_ADDR;
				bit_cnt     <= 3'h0;
				byte_full   <= 1'b0;
				second_byte <= 1'b0;
				sda_oe_n    <= 1'b1;
			end else if (stop_seen) begin
				state    <= mxs_pkg::MXS_IDLE;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state)
				mxs_pkg::MXS_ADDR, mxs_pkg::MXS_WR_BYTE: begin
					rx_shift  <= rx_next;
					bit_cnt   <= bit_cnt + 3'h1;
					byte_full <= (bit_cnt == mxs_pkg::BIT_LAST);
					if (state == mxs_pkg::MXS_WR_BYTE &&
					    bit_cnt == mxs_pkg::BIT_LAST) begin
						if (!second_byte)
							cmd_byte <= rx_next;
						second_byte <= ~second_byte;
					end
				end
				mxs_pkg::MXS_RD_BYTE: begin
					bit_cnt   <= bit_cnt + 3'h1;
					byte_full <= (bit_cnt == mxs_pkg::BIT_LAST);
				end
				mxs_pkg::MXS_RD_ACK: begin
					// Master acknowledge asks for the low byte
					rd_more <= ~sda_s & ~rd_low;
				end
				default: begin
				end
				endcase
			end else if (scl_fall) begin
				byte_full <= 1'b0;
				case (state)
				mxs_pkg::MXS_ADDR: begin
					if (byte_full && rx_shift[7:1] ==
					    {mxs_pkg::ADDR_FIXED, addr_q}) begin
						state    <= mxs_pkg::MXS_ADDR_ACK;
						is_read  <= rx_shift[0];
						sda_oe_n <= 1'b0;
					end else if (byte_full) begin
						state <= mxs_pkg::MXS_IDLE;
					end
				end
				mxs_pkg::MXS_ADDR_ACK: begin
					bit_cnt <= 3'h0;
					if (is_read) begin
						state    <= mxs_pkg::MXS_RD_BYTE;
						rd_low   <= 1'b0;
						tx_shift <= status_word[15:8];
						sda_oe_n <= status_word[15];
					end else begin
						state    <= mxs_pkg::MXS_WR_BYTE;
						sda_oe_n <= 1'b1;
					end
				end
				mxs_pkg::MXS_WR_BYTE: begin
					if (byte_full) begin
						state    <= mxs_pkg::MXS_WR_ACK;
						sda_oe_n <= 1'b0;
					end
				end
				mxs_pkg::MXS_WR_ACK: begin
					state    <= mxs_pkg::MXS_WR_BYTE;
					sda_oe_n <= 1'b1;
				end
				mxs_pkg::MXS_RD_BYTE: begin
					if (byte_full) begin
						// Release so the master can acknowledge
						state    <= mxs_pkg::MXS_RD_ACK;
						sda_oe_n <= 1'b1;
					end else begin
						sda_oe_n <= tx_shift[6];
						tx_shift <= {tx_shift[6:0], 1'b0};
					end
				end
				mxs_pkg::MXS_RD_ACK: begin
					if (rd_more) begin
						state    <= mxs_pkg::MXS_RD_BYTE;
						rd_low   <= 1'b1;
						bit_cnt  <= 3'h0;
						tx_shift <= status_word[7:0];
						sda_oe_n <= status_word[7];
					end else begin
						state    <= mxs_pkg::MXS_IDLE;
						sda_oe_n <= 1'b1;
					end
					rd_more <= 1'b0;
				end
				default: begin
					state <= mxs_pkg::MXS_IDLE;
				end
				endcase
			end
		end
	end
	// Switch state: staged copy and applied copy, updated per control byte
	always_ff @(posedge clock) begin
		if (!nrst) begin
			applied <= mxs_pkg::STATE_RESET;
			staged  <= mxs_pkg::STATE_RESET;
		end else if (ctl_taken) begin
			if (!rx_next[mxs_pkg::CTL_RST_N_BIT]) begin
				applied <= mxs_pkg::STATE_RESET;
				staged  <= mxs_pkg::STATE_RESET;
			end else begin
				staged <= next_staged;
				if (rx_next[mxs_pkg::CTL_LOAD_BIT])
					applied <= next_staged;
			end
		end
	end
	// Pin outputs follow the applied copy; closed reads as one
	always_ff @(posedge clock) begin
		if (!nrst) begin
			switch_closed      <= 10'h000;
			general_output_pin <= 1'b0;
		end else if (clk_en) begin
			switch_closed      <= applied[9:0];
			general_output_pin <= applied[10] & HAS_GEN_OUT;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_soft_reset_clear: assert property (
		ctl_taken && !rx_next[mxs_pkg::CTL_RST_N_BIT]
		|=> applied == 11'h000 ##2 (switch_closed == 10'h000 || !clk_en))
		else $error("soft reset did not open every switch");
	chk_load_applies: assert property (
		ctl_taken && rx_next[1] && rx_next[0]
		|=> applied == $past(next_staged))
		else $error("load strobe did not apply staged state");
	chk_hold_unloaded: assert property (
		ctl_taken && !rx_next[1] && rx_next[0] |=> $stable(applied))
		else $error("applied state moved without load strobe");
	chk_staged_wins: assert property (
		ctl_taken && rx_next[0] && mask[9]
		|=> staged[9] == $past(cmd_byte[7] & ~cmd_off))
		else $error("latest command did not win in staging");
	chk_read_high_byte: assert property (
		clk_en && scl_fall && state == mxs_pkg::MXS_ADDR_ACK && is_read
		|=> tx_shift == $past(applied[9:2]) && sda_oe_n == $past(applied[9]))
		else $error("read did not start with switch status");
	chk_spare_bits_zero: assert property (
		clk_en && scl_fall && state == mxs_pkg::MXS_RD_ACK && rd_more |=>
		tx_shift[5:0] == {2'b00, $past(applied[10]) & HAS_GEN_OUT, 3'b000})
		else $error("unassigned readback bit not zero");
	chk_addr_ack_match: assert property (
		state == mxs_pkg::MXS_ADDR_ACK |-> !sda_oe_n &&
		rx_shift[7:4] == mxs_pkg::ADDR_FIXED && rx_shift[3:1] == addr_q)
		else $error("acknowledged a foreign address");
	chk_master_ack_free: assert property (
		state == mxs_pkg::MXS_RD_ACK || state == mxs_pkg::MXS_IDLE
		|-> sda_oe_n)
		else $error("data line held during master acknowledge");
	chk_gen_out_pin: assert property (
		clk_en ##1 clk_en |->
		general_output_pin == ($past(applied[10]) & HAS_GEN_OUT))
		else $error("output pin does not follow applied level");
	cov_write_load: cover property (ctl_taken && rx_next[1] && rx_next[0]);
	cov_soft_reset: cover property (ctl_taken && !rx_next[0]);
	cov_read_two: cover property (state == mxs_pkg::MXS_RD_BYTE && rd_low
		&& byte_full);
endmodule : mxs_switch_ctrl

/* File: verification/mxs_master_model.sv */
// Two-wire bus master model that frames writes and reads to the switch.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module mxs_master_model (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	// Bus rests released; scl stands high between frames
	initial begin
		scl     = 1'b1;
		sda_drv = 1'b1;
	end

	// Every change lands just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// Data moves only while scl is low, sampled in mid-high
	task automatic bit_xfer(input logic b, output logic r);
		sda_drv = b;
		tick(2);
		scl = 1'b1;
		tick(2);
		r = sda;
		tick(2);
		scl = 1'b0;
		tick(2);
	endtask : bit_xfer

	// Works as a repeated start too, since sda rises while scl is low
	task automatic frame_start();
		sda_drv = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask : frame_start

	task automatic frame_stop();
		sda_drv = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b1;
		tick(4);
	endtask : frame_stop

	// Eight bits MSB first, then the acknowledge slot
	task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], b);
			r[i] = b;
		end
		bit_xfer(ack_in, ack);
	endtask : byte_xfer
endmodule : mxs_master_model

/* File: verification/testbench.sv */
// Self-checking bench: writes and reads the switch over the two-wire bus.
// Assumes the master model and a pull-up on the data wire.
`timescale 1ns/10ps
module testbench;
	logic        clock;
	logic        nrst;
	logic        clk_en;
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe_n;
	logic [2:0]  asel;
	logic [9:0]  switch_closed;
	logic        general_output_pin;
	wire         sda;
	int          n_errors;
	int          comparisons;
	logic [7:0]  cmds [9];
	logic [10:0] exps [9];
	logic [15:0] word;
	logic [9:0]  e;
	logic        ack;

	// Wired-and with pull-up: either party pulling low wins
	assign sda = (sda_oe_n === 1'b0 ? sda_out : 1'b1) & sda_drv;

	initial clock = 1'b0;
	always #20 clock = ~clock;

	mxs_switch_ctrl u_dut (.clock, .nrst, .clk_en, .scl_in(scl),
		.sda_in(sda), .sda_out, .sda_oe_n, .addr_select_2(asel[2]),
		.addr_select_1(asel[1]), .addr_select_0(asel[0]),
		.switch_closed, .general_output_pin);

	mxs_master_model u_master (.clock, .sda, .scl, .sda_drv);

	task automatic chk(input string nm, input logic [15:0] x,
		input logic [15:0] s);
		comparisons++;
		if (s !== x) begin
			$display("Error %s expected %h seen %h", nm, x, s);
			n_errors++;
		end
	endtask : chk

	// One command byte and one control byte per frame
	task automatic wr(input logic [7:0] cmd, input logic [1:0] ctl);
		logic [7:0] r;
		logic       a;
		u_master.frame_start();
		u_master.byte_xfer({4'ha, asel, 1'b0}, 1'b1, r, a);
		chk("addr ack", 16'h0000, {15'h0000, a});
		u_master.byte_xfer(cmd, 1'b1, r, a);
		chk("cmd ack", 16'h0000, {15'h0000, a});
		// Spare control bits carry a pattern the block must ignore
		u_master.byte_xfer({6'h2a, ctl}, 1'b1, r, a);
		chk("ctl ack", 16'h0000, {15'h0000, a});
		u_master.frame_stop();
	endtask : wr

	// Master acks the high byte and refuses the low one
	task automatic rd(output logic [15:0] w);
		logic a;
		u_master.frame_start();
		u_master.byte_xfer({4'ha, asel, 1'b1}, 1'b1, w[15:8], a);
		chk("read ack", 16'h0000, {15'h0000, a});
		u_master.byte_xfer(8'hff, 1'b0, w[15:8], a);
		u_master.byte_xfer(8'hff, 1'b1, w[7:0], a);
		u_master.frame_stop();
	endtask : rd

	task automatic conclude();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Seen state packed as output level over the ten switches
	function automatic logic [15:0] seen();
		return {5'h00, general_output_pin, switch_closed};
	endfunction : seen

	initial begin
		n_errors = 0;
		comparisons = 0;
		nrst = 1'b0;
		clk_en = 1'b1;
		asel = 3'h5;
		cmds = '{8'h0e, 8'h80, 8'h01, 8'h12, 8'h81, 8'h8c, 8'h9f,
			8'h1f, 8'h14};
		exps = '{11'h442, 11'h6ea, 11'h6aa, 11'h6a8, 11'h7fd, 11'h7fd,
			11'h7fd, 11'h400, 11'h000};
		repeat (20) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		chk("reset state", 16'h0000, seen());
		rd(word);
		chk("reset read", 16'h0000, word);
		wr(8'h82, 2'h3);
		chk("immediate", 16'h0200, seen());
		rd(word);
		chk("one switch read", 16'h8000, word);
		// Staged commands stay hidden until the final strobe
		wr(8'h85, 2'h1);
		wr(8'h94, 2'h1);
		wr(8'h8b, 2'h1);
		wr(8'h0b, 2'h1);
		chk("staged hidden", 16'h0200, seen());
		rd(word);
		chk("staged read", 16'h8000, word);
		wr(8'h8a, 2'h3);
		chk("joint apply", 16'h0642, seen());
		rd(word);
		chk("output read", 16'h9088, word);
		// Clock enable low: the whole frame must pass unseen
		clk_en = 1'b0;
		u_master.frame_start();
		u_master.byte_xfer({4'ha, asel, 1'b0}, 1'b1,
			word[7:0], ack);
		chk("frozen ack", 16'h0001, {15'h0000, ack});
		u_master.frame_stop();
		clk_en = 1'b1;
		chk("frozen state", 16'h0642, seen());
		// Group, disable, reserved and output targets
		for (int i = 0; i < 9; i++) begin
			wr(cmds[i], 2'h3);
			chk("group cmd", {5'h00, exps[i]}, seen());
		end
		// Each single switch on, then each off again
		e = 10'h000;
		for (int i = 0; i < 10; i++) begin
			wr(8'h82 + 8'(i), 2'h3);
			e = e | (10'h200 >> i);
			chk("single on", {6'h00, e}, seen());
		end
		for (int i = 0; i < 10; i++) begin
			wr(8'h02 + 8'(i), 2'h3);
			e = e & ~(10'h200 >> i);
			chk("single off", {6'h00, e}, seen());
		end
		// A foreign address gets no acknowledge
		u_master.frame_start();
		u_master.byte_xfer({4'ha, 3'h2, 1'b0}, 1'b1,
			word[7:0], ack);
		chk("foreign ack", 16'h0001, {15'h0000, ack});
		u_master.frame_stop();
		// A second power-on reset in mid-run opens everything
		wr(8'h86, 2'h3);
		wr(8'h94, 2'h3);
		chk("before reset", 16'h0420, seen());
		nrst = 1'b0;
		repeat (4) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		chk("power reset", 16'h0000, seen());
		rd(word);
		chk("power readback", 16'h0000, word);
		// Soft reset wins over load and over a pending command
		wr(8'h82, 2'h3);
		wr(8'h94, 2'h3);
		wr(8'h85, 2'h2);
		chk("soft reset", 16'h0000, seen());
		wr(8'h82, 2'h3);
		wr(8'h85, 2'h0);
		chk("reset no load", 16'h0000, seen());
		rd(word);
		chk("reset readback", 16'h0000, word);
		conclude();
	end
endmodule : testbench
